// ---- rtl/mdcu_pkg.sv ----
// Purpose: shared constants and types for the management command block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package mdcu_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int          MDCU_AW         = 12;
    localparam logic [11:0] MDCU_RAW_OFF    = 12'h000;
    localparam logic [11:0] MDCU_MASKED_OFF = 12'h004;
    localparam logic [11:0] MDCU_ENSET_OFF  = 12'h008;
    localparam logic [11:0] MDCU_ENCLR_OFF  = 12'h00C;
    localparam logic [11:0] MDCU_CMD0_OFF   = 12'h010;
    localparam logic [11:0] MDCU_CMD1_OFF   = 12'h014;
    localparam logic [11:0] MDCU_CTRL_OFF   = 12'h018;

    // ****************************************
    // command word layout
    // ****************************************
    localparam int MDCU_NCH       = 2;
    localparam int MDCU_GO_BIT    = 31;
    localparam int MDCU_WR_BIT    = 30;
    localparam int MDCU_ACK_BIT   = 29;
    localparam int MDCU_RSV_HI    = 28;
    localparam int MDCU_RSV_LO    = 26;
    localparam int MDCU_REG_HI    = 25;
    localparam int MDCU_REG_LO    = 21;
    localparam int MDCU_PHY_HI    = 20;
    localparam int MDCU_PHY_LO    = 16;
    localparam int MDCU_DATA_HI   = 15;
    localparam int MDCU_IDX_W     = 5;
    localparam int MDCU_DATA_W    = 16;
    localparam int MDCU_CTRL_EN   = 0;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] MDCU_ZERO32   = 32'h0000_0000;
    localparam logic [1:0]  MDCU_EN_RST   = 2'h0;
    localparam logic [1:0]  MDCU_RAW_RST  = 2'h0;
    localparam logic [2:0]  MDCU_RSV_VAL  = 3'h0;

    typedef enum logic [0:0] {
        MDCU_IDLE = 1'b0,
        MDCU_BUSY = 1'b1
    } mdcu_state_t;

endpackage

// ---- rtl/mdcu_chan_if.sv ----
// Purpose: carrier between the register front end and one command channel
// Assumes: single core clock
// Notes:   one instance per channel
`timescale 1ns/100ps
interface mdcu_chan_if;
    logic        wr_en;
    logic [31:0] wdata;
    logic        sm_enable;
    logic        done;
    logic        rd_ack;
    logic [15:0] rd_data;
    logic [31:0] word;
    logic        busy;
    logic        done_evt;

    modport chan (input wr_en, wdata, sm_enable, done, rd_ack, rd_data,
                  output word, busy, done_evt);
    modport ctrl (output wr_en, wdata, sm_enable, done, rd_ack, rd_data,
                  input word, busy, done_evt);
endinterface

// ---- rtl/mdcu_chan.sv ----
// Purpose: one user command channel, holds the command word and launch bit
// Assumes: done is a one-cycle pulse only while busy
// Notes:   writes are dropped while a launch is pending
`timescale 1ns/100ps
module mdcu_chan
    import mdcu_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic sys_rst,
    mdcu_chan_if.chan cif
);

    logic                   go;
    logic                   wsel;
    logic                   ack;
    logic [MDCU_IDX_W-1:0]  reg_idx;
    logic [MDCU_IDX_W-1:0]  phy_addr;
    logic [MDCU_DATA_W-1:0] data;
    logic                   next_go;
    logic                   next_wsel;
    logic                   next_ack;
    logic [MDCU_IDX_W-1:0]  next_reg_idx;
    logic [MDCU_IDX_W-1:0]  next_phy_addr;
    logic [MDCU_DATA_W-1:0] next_data;

    always_comb begin
        next_go       = go;
        next_wsel     = wsel;
        next_ack      = ack;
        next_reg_idx  = reg_idx;
        next_phy_addr = phy_addr;
        next_data     = data;
        if (go) begin
            if (cif.done) begin
                next_go = 1'b0;
                if (!wsel) begin
                    next_data = cif.rd_data;
                    next_ack  = cif.rd_ack;
                end
            end
        end else if (cif.wr_en) begin
            next_go       = cif.wdata[MDCU_GO_BIT] & cif.sm_enable;
            next_wsel     = cif.wdata[MDCU_WR_BIT];
            next_ack      = cif.wdata[MDCU_ACK_BIT];
            next_reg_idx  = cif.wdata[MDCU_REG_HI:MDCU_REG_LO];
            next_phy_addr = cif.wdata[MDCU_PHY_HI:MDCU_PHY_LO];
            next_data     = cif.wdata[MDCU_DATA_HI:0];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            go       <= 1'b0;
            wsel     <= 1'b0;
            ack      <= 1'b0;
            reg_idx  <= '0;
            phy_addr <= '0;
            data     <= '0;
        end else begin
            go       <= next_go;
            wsel     <= next_wsel;
            ack      <= next_ack;
            reg_idx  <= next_reg_idx;
            phy_addr <= next_phy_addr;
            data     <= next_data;
        end
    end

    // reserved bits read as zero
    assign cif.word     = {go, wsel, ack, MDCU_RSV_VAL, reg_idx, phy_addr, data};
    assign cif.busy     = go;
    assign cif.done_evt = go & cif.done;

    // ****************************************
    // checks
    // ****************************************
    go_block_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && !cif.done |=> $stable(cif.word))
        else $error("command word changed while launch pending");
    go_disabled_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !go && cif.wr_en && !cif.sm_enable |=> !go)
        else $error("launch set while engine disabled");
    rsv_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        cif.word[MDCU_RSV_HI:MDCU_RSV_LO] == MDCU_RSV_VAL)
        else $error("reserved bits not zero");
    go_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && cif.done |=> !go ##0 (wsel || data == $past(cif.rd_data)))
        else $error("launch bit or read data wrong after completion");

endmodule

// ---- rtl/mdcu_top.sv ----
// Purpose: user command channels and command-complete interrupt masking
// Assumes: frame engine outside answers eng_req with one eng_done pulse
// Notes:   APB slave, zero wait states, pslverr on unmapped addresses
//
// Functional notes
// - writing 1 to an enable-set bit enables that channel's completion interrupt
// - enable-set bit 0 serves channel 0, bit 1 serves channel 1
// - reading enable-set returns the current per-channel enables
// - writing 0 to enable-set or enable-clear bits changes nothing
// - writing 1 to an enable-clear bit disables that channel's interrupt
// - enable-clear bit 0 serves channel 0, bit 1 serves channel 1
// - each enable gates its own bit of the masked completion status
// - command word holds launch, write-select, ack, reserved, index, address, data
// - low sixteen bits carry data written to or read from the PHY
// - launch is write-one-to-set, others read/write, reserved read zero, reset zero
// - launch settable only when enabled, self-clears, blocks writes while set
// - write-select chooses write or read; ack set when PHY acknowledged read
// - completion sets raw event bit; write 1 clears, write 0 ignored
// - masked bit is raw and enable; writing 1 there clears the event
`timescale 1ns/100ps
module mdcu_top
    import mdcu_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [MDCU_AW-1:0]    paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       cmd_done_irq,
    output logic                       eng_req,
    output logic                       eng_write,
    output logic      [MDCU_IDX_W-1:0] eng_reg_idx,
    output logic      [MDCU_IDX_W-1:0] eng_phy_addr,
    output logic      [MDCU_DATA_W-1:0] eng_wdata,
    input  wire logic                  eng_done,
    input  wire logic                  eng_ack,
    input  wire logic [MDCU_DATA_W-1:0] eng_rdata
);

    // ****************************************
    // decode
    // ****************************************
    function automatic logic addr_known(input logic [MDCU_AW-1:0] a);
        addr_known = (a == MDCU_RAW_OFF) || (a == MDCU_MASKED_OFF) ||
                     (a == MDCU_ENSET_OFF) || (a == MDCU_ENCLR_OFF) ||
                     (a == MDCU_CMD0_OFF) || (a == MDCU_CMD1_OFF) ||
                     (a == MDCU_CTRL_OFF);
    endfunction

    logic                    wr_acc;
    logic                    rd_setup;
    logic [MDCU_NCH-1:0]     en;
    logic [MDCU_NCH-1:0]     raw;
    logic                    sm_en;
    logic [MDCU_NCH-1:0]     next_en;
    logic [MDCU_NCH-1:0]     next_raw;
    logic                    next_sm_en;
    logic [MDCU_NCH-1:0]     masked;
    logic [MDCU_NCH-1:0]     set_bits;
    logic [MDCU_NCH-1:0]     clr_bits;
    logic [MDCU_NCH-1:0]     evt_clr;
    logic [MDCU_NCH-1:0]     done_evt;
    logic [MDCU_NCH-1:0]     busy;
    logic [31:0]             word [MDCU_NCH];
    logic [31:0]             next_prdata;

    assign wr_acc   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~addr_known(paddr);

    // ****************************************
    // interrupt enables and events
    // ****************************************
    assign set_bits = (wr_acc && paddr == MDCU_ENSET_OFF) ? pwdata[MDCU_NCH-1:0] : '0;
    assign clr_bits = (wr_acc && paddr == MDCU_ENCLR_OFF) ? pwdata[MDCU_NCH-1:0] : '0;
    assign evt_clr  = (wr_acc && (paddr == MDCU_RAW_OFF || paddr == MDCU_MASKED_OFF)) ?
                      pwdata[MDCU_NCH-1:0] : '0;
    assign masked   = raw & en;
    assign cmd_done_irq = |masked;

    always_comb begin
        next_en  = (en | set_bits) & ~clr_bits;
        next_raw = (raw & ~evt_clr) | done_evt;
        next_sm_en = sm_en;
        if (wr_acc && paddr == MDCU_CTRL_OFF) begin
            next_sm_en = pwdata[MDCU_CTRL_EN];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en    <= MDCU_EN_RST;
            raw   <= MDCU_RAW_RST;
            sm_en <= 1'b0;
        end else begin
            en    <= next_en;
            raw   <= next_raw;
            sm_en <= next_sm_en;
        end
    end

    // ****************************************
    // read data, captured in the setup cycle
    // ****************************************
    always_comb begin
        next_prdata = prdata;
        if (rd_setup) begin
            case (paddr)
                MDCU_RAW_OFF:    next_prdata = {30'h0000_0000, raw};
                MDCU_MASKED_OFF: next_prdata = {30'h0000_0000, masked};
                MDCU_ENSET_OFF:  next_prdata = {30'h0000_0000, en};
                MDCU_ENCLR_OFF:  next_prdata = {30'h0000_0000, en};
                MDCU_CMD0_OFF:   next_prdata = word[0];
                MDCU_CMD1_OFF:   next_prdata = word[1];
                MDCU_CTRL_OFF:   next_prdata = {31'h0000_0000, sm_en};
                default:         next_prdata = MDCU_ZERO32;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= MDCU_ZERO32;
        end else begin
            prdata <= next_prdata;
        end
    end

    // ****************************************
    // channels
    // ****************************************
    mdcu_state_t       state;
    mdcu_state_t       next_state;
    logic [0:0]        cur;
    logic [0:0]        next_cur;

    genvar gi;
    generate
        for (gi = 0; gi < MDCU_NCH; gi++) begin : g_ch
            mdcu_chan_if cif ();
            assign cif.wr_en     = wr_acc &&
                                   paddr == (gi == 0 ? MDCU_CMD0_OFF : MDCU_CMD1_OFF);
            assign cif.wdata     = pwdata;
            assign cif.sm_enable = sm_en;
            assign cif.done      = (state == MDCU_BUSY) && eng_done && (cur == gi);
            assign cif.rd_ack    = eng_ack;
            assign cif.rd_data   = eng_rdata;
            assign word[gi]      = cif.word;
            assign busy[gi]      = cif.busy;
            assign done_evt[gi]  = cif.done_evt;
            mdcu_chan u_chan (
                .core_clk (core_clk),
                .sys_rst  (sys_rst),
                .cif      (cif)
            );
        end
    endgenerate

    // ****************************************
    // engine arbiter, channel 0 first
    // ****************************************
    logic                   next_eng_write;
    logic [MDCU_IDX_W-1:0]  next_eng_reg_idx;
    logic [MDCU_IDX_W-1:0]  next_eng_phy_addr;
    logic [MDCU_DATA_W-1:0] next_eng_wdata;

    always_comb begin
        next_state        = state;
        next_cur          = cur;
        next_eng_write    = eng_write;
        next_eng_reg_idx  = eng_reg_idx;
        next_eng_phy_addr = eng_phy_addr;
        next_eng_wdata    = eng_wdata;
        case (state)
            MDCU_IDLE: begin
                if (|busy) begin
                    next_cur          = busy[0] ? 1'b0 : 1'b1;
                    next_state        = MDCU_BUSY;
                    next_eng_write    = word[next_cur][MDCU_WR_BIT];
                    next_eng_reg_idx  = word[next_cur][MDCU_REG_HI:MDCU_REG_LO];
                    next_eng_phy_addr = word[next_cur][MDCU_PHY_HI:MDCU_PHY_LO];
                    next_eng_wdata    = word[next_cur][MDCU_DATA_HI:0];
                end
            end
            MDCU_BUSY: begin
                if (eng_done) begin
                    next_state = MDCU_IDLE;
                end
            end
            default: next_state = MDCU_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state        <= MDCU_IDLE;
            cur          <= 1'b0;
            eng_write    <= 1'b0;
            eng_reg_idx  <= '0;
            eng_phy_addr <= '0;
            eng_wdata    <= '0;
        end else begin
            state        <= next_state;
            cur          <= next_cur;
            eng_write    <= next_eng_write;
            eng_reg_idx  <= next_eng_reg_idx;
            eng_phy_addr <= next_eng_phy_addr;
            eng_wdata    <= next_eng_wdata;
        end
    end

    assign eng_req = (state == MDCU_BUSY);

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    en_set_a: assert property (
        wr_acc && paddr == MDCU_ENSET_OFF |=> (en & $past(pwdata[1:0])) == $past(pwdata[1:0]))
        else $error("enable not set by write one");
    en_set_zero_a: assert property (
        wr_acc && paddr == MDCU_ENSET_OFF && pwdata[1:0] == 2'h0 |=> $stable(en))
        else $error("enable changed by write zero");
    en_clr_a: assert property (
        wr_acc && paddr == MDCU_ENCLR_OFF |=> (en & $past(pwdata[1:0])) == 2'h0
            ##0 (en | $past(pwdata[1:0])) == ($past(en) | $past(pwdata[1:0])))
        else $error("enable clear wrong");
    en_read_a: assert property (
        rd_setup && paddr == MDCU_ENSET_OFF |=> prdata == {30'h0000_0000, $past(en)})
        else $error("enable readback wrong");
    irq_gate_a: assert property (
        cmd_done_irq == ((raw[0] && en[0]) || (raw[1] && en[1])))
        else $error("interrupt output does not follow masked status");
    raw_set_a: assert property (
        state == MDCU_BUSY && eng_done |=> raw[$past(cur)])
        else $error("completion event not recorded");
    raw_keep_a: assert property (
        wr_acc && paddr == MDCU_RAW_OFF && pwdata[1:0] == 2'h0 && done_evt == 2'h0
            |=> raw == $past(raw))
        else $error("raw event changed by write zero");
    eng_hold_a: assert property (
        state == MDCU_BUSY && !eng_done |=> eng_req && $stable(eng_write) && $stable(eng_wdata))
        else $error("engine request changed mid access");

    launch_c: cover property (state == MDCU_IDLE && |busy ##1 eng_req);
    irq_c:    cover property (!cmd_done_irq ##1 cmd_done_irq);
    both_c:   cover property (busy == 2'h3 ##[1:50] raw == 2'h3);

endmodule

// ---- tb/mdcu_phy_model.sv ----
// Purpose: behavioural frame engine and PHY on the far side of the command block
// Assumes: one eng_done pulse per eng_req, latency set by lat
// Notes:   read data is {phy address, register index, 6'h2A}
`timescale 1ns/100ps
module mdcu_phy_model
    import mdcu_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   eng_req,
    input  wire logic                   eng_write,
    input  wire logic [MDCU_IDX_W-1:0]  eng_reg_idx,
    input  wire logic [MDCU_IDX_W-1:0]  eng_phy_addr,
    input  wire logic [MDCU_DATA_W-1:0] eng_wdata,
    input  wire logic [3:0]             lat,
    input  wire logic                   ack_en,
    output logic                        eng_done,
    output logic                        eng_ack,
    output logic      [MDCU_DATA_W-1:0] eng_rdata,
    output logic      [MDCU_DATA_W-1:0] last_wdata
);
    logic [3:0] cnt;

    // ****************************************
    // answer lat+1 cycles after eng_req rises, garbage outside done
    // ****************************************
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 4'h0;
            eng_done <= 1'b0;
            eng_ack <= 1'b0;
            eng_rdata <= 16'hA5A5;
            last_wdata <= 16'h0000;
        end else if (eng_req && !eng_done && cnt >= lat) begin
            eng_done <= 1'b1;
            eng_ack <= ack_en & ~eng_write;
            eng_rdata <= {eng_phy_addr, eng_reg_idx, 6'h2A};
            cnt <= 4'h0;
            if (eng_write) begin
                last_wdata <= eng_wdata;
            end
        end else begin
            eng_done <= 1'b0;
            eng_ack <= ~eng_ack;
            eng_rdata <= ~eng_rdata;
            cnt <= (eng_req && !eng_done) ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// ---- tb/test_mdio_user_cmd_irq_mask_access.sv ----
// Purpose: register-level test of command channels and completion interrupt masks
// Assumes: APB with pready tied high, engine answered by mdcu_phy_model
// Notes:   expected values derived from the command word layout
`timescale 1ns/100ps
module test_mdio_user_cmd_irq_mask_access;
    import mdcu_pkg::*;

    logic                   core_clk = 1'b0;
    logic                   sys_rst  = 1'b1;
    logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [MDCU_AW-1:0]     paddr = 12'h000;
    logic [31:0]            pwdata = 32'h0000_0000;
    logic [31:0]            prdata, q;
    logic                   pready, pslverr, cmd_done_irq, last_err;
    logic                   eng_req, eng_write, eng_done, eng_ack;
    logic [MDCU_IDX_W-1:0]  eng_reg_idx, eng_phy_addr;
    logic [MDCU_DATA_W-1:0] eng_wdata, eng_rdata, last_wdata;
    logic [3:0]             lat = 4'hF;
    logic                   ack_en = 1'b1;
    int                     n_mismatch = 0;
    int                     check_count = 0;
    logic [11:0]            offs [7] = '{MDCU_RAW_OFF, MDCU_MASKED_OFF, MDCU_ENSET_OFF,
                                         MDCU_ENCLR_OFF, MDCU_CMD0_OFF, MDCU_CMD1_OFF,
                                         MDCU_CTRL_OFF};

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    mdcu_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd_done_irq(cmd_done_irq), .eng_req(eng_req),
        .eng_write(eng_write), .eng_reg_idx(eng_reg_idx), .eng_phy_addr(eng_phy_addr),
        .eng_wdata(eng_wdata), .eng_done(eng_done), .eng_ack(eng_ack), .eng_rdata(eng_rdata));

    mdcu_phy_model phy (.core_clk(core_clk), .sys_rst(sys_rst), .eng_req(eng_req),
        .eng_write(eng_write), .eng_reg_idx(eng_reg_idx), .eng_phy_addr(eng_phy_addr),
        .eng_wdata(eng_wdata), .lat(lat), .ack_en(ack_en), .eng_done(eng_done),
        .eng_ack(eng_ack), .eng_rdata(eng_rdata), .last_wdata(last_wdata));

    // ****************************************
    // access and compare tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check("pready", 32'h1, {31'h0, pready});
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(name, exp, q);
    endtask

    task automatic wait_idle(input logic [11:0] a);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0000_0000);
            n++;
        end while (q[MDCU_GO_BIT] !== 1'b0 && n < 40);
        check("launch clear", 32'h0, {31'h0, q[MDCU_GO_BIT]});
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        final_report();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        foreach (offs[i]) rd_chk("reset value", offs[i], 32'h0000_0000);
        $display("test reset_values done");
        wr(MDCU_ENSET_OFF, 32'hFFFF_FFFD);
        rd_chk("enable set", MDCU_ENSET_OFF, 32'h0000_0001);
        wr(MDCU_ENSET_OFF, 32'h0000_0000);
        rd_chk("enable set", MDCU_ENSET_OFF, 32'h0000_0001);
        wr(MDCU_ENSET_OFF, 32'h0000_0002);
        rd_chk("enable set", MDCU_ENSET_OFF, 32'h0000_0003);
        wr(MDCU_ENCLR_OFF, 32'h0000_0000);
        rd_chk("enable clear", MDCU_ENCLR_OFF, 32'h0000_0003);
        wr(MDCU_ENCLR_OFF, 32'h0000_0001);
        rd_chk("enable set", MDCU_ENSET_OFF, 32'h0000_0002);
        wr(MDCU_ENCLR_OFF, 32'h0000_0002);
        rd_chk("enable set", MDCU_ENSET_OFF, 32'h0000_0000);
        wr(MDCU_ENSET_OFF, 32'h0000_0001);
        rd_chk("unmapped read", 12'h01C, 32'h0000_0000);
        check("unmapped error", 32'h1, {31'h0, last_err});
        $display("test enable_masks done");
        wr(MDCU_CMD0_OFF, 32'hFFFF_FFFF);
        rd_chk("cmd0 disabled", MDCU_CMD0_OFF, 32'h63FF_FFFF);
        check("engine request", 32'h0, {31'h0, eng_req});
        wr(MDCU_CTRL_OFF, 32'h0000_0001);
        wr(MDCU_CMD0_OFF, 32'hC0A3_1234);
        rd_chk("cmd0 launched", MDCU_CMD0_OFF, 32'hC0A3_1234);
        wr(MDCU_CMD0_OFF, 32'h0000_0000);
        rd_chk("cmd0 blocked", MDCU_CMD0_OFF, 32'hC0A3_1234);
        check("engine fields", {1'b1, 1'b1, 5'd5, 5'd3, 16'h1234},
              {eng_req, eng_write, eng_reg_idx, eng_phy_addr, eng_wdata});
        wait_idle(MDCU_CMD0_OFF);
        rd_chk("cmd0 done", MDCU_CMD0_OFF, 32'h40A3_1234);
        check("phy write data", 32'h1234, {16'h0, last_wdata});
        rd_chk("raw status", MDCU_RAW_OFF, 32'h0000_0001);
        rd_chk("masked status", MDCU_MASKED_OFF, 32'h0000_0001);
        check("irq", 32'h1, {31'h0, cmd_done_irq});
        wr(MDCU_MASKED_OFF, 32'h0000_0001);
        rd_chk("raw status", MDCU_RAW_OFF, 32'h0000_0000);
        check("irq", 32'h0, {31'h0, cmd_done_irq});
        $display("test channel0_write done");
        lat <= 4'h0;
        wr(MDCU_CMD1_OFF, 32'h80E9_0000);
        wait_idle(MDCU_CMD1_OFF);
        rd_chk("cmd1 read", MDCU_CMD1_OFF, {6'b001000, 5'd7, 5'd9, 5'd9, 5'd7, 6'h2A});
        rd_chk("raw status", MDCU_RAW_OFF, 32'h0000_0002);
        rd_chk("masked status", MDCU_MASKED_OFF, 32'h0000_0000);
        check("irq", 32'h0, {31'h0, cmd_done_irq});
        wr(MDCU_ENSET_OFF, 32'h0000_0002);
        rd_chk("masked status", MDCU_MASKED_OFF, 32'h0000_0002);
        check("irq", 32'h1, {31'h0, cmd_done_irq});
        wr(MDCU_RAW_OFF, 32'h0000_0000);
        rd_chk("raw status", MDCU_RAW_OFF, 32'h0000_0002);
        wr(MDCU_RAW_OFF, 32'h0000_0002);
        rd_chk("raw status", MDCU_RAW_OFF, 32'h0000_0000);
        check("irq", 32'h0, {31'h0, cmd_done_irq});
        $display("test channel1_read done");
        lat <= 4'h3;
        ack_en <= 1'b0;
        wr(MDCU_ENCLR_OFF, 32'h0000_0001);
        wr(MDCU_CMD0_OFF, 32'h8022_0000);
        wait_idle(MDCU_CMD0_OFF);
        rd_chk("cmd0 no ack", MDCU_CMD0_OFF, {6'b000000, 5'd1, 5'd2, 5'd2, 5'd1, 6'h2A});
        rd_chk("raw status", MDCU_RAW_OFF, 32'h0000_0001);
        rd_chk("masked status", MDCU_MASKED_OFF, 32'h0000_0000);
        check("irq", 32'h0, {31'h0, cmd_done_irq});
        $display("test channel0_read done");
        lat <= 4'hF;
        wr(MDCU_RAW_OFF, 32'h0000_0001);
        wr(MDCU_CMD0_OFF, 32'hC0A3_5678);
        wr(MDCU_CMD1_OFF, 32'hC0A3_9ABC);
        wait_idle(MDCU_CMD1_OFF);
        rd_chk("raw status", MDCU_RAW_OFF, 32'h0000_0003);
        check("phy write data", 32'h9ABC, {16'h0, last_wdata});
        rd_chk("cmd0 done", MDCU_CMD0_OFF, 32'h40A3_5678);
        $display("test both_channels done");
        final_report();
    end
endmodule
